// ==== mlr_exec.sv ====
// execution slice: moves, or, returns, rotates, subtract, decrement-skip
// assumes memory read data arrives with the instruction, same cycle
`timescale 1ns/1ps
`default_nettype none
`include "mlr_consts.svh"

module mlr_exec
  import mlr_pkg::*;
(
  input wire logic core_clk, // core clock, 200 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes all state
  input wire logic instr_valid, // instruction offered
  input wire mlr_op_t instr_op, // instruction selector
  input wire logic [`MLR_DATA_W-1:0] instr_imm, // immediate field
  input wire logic [`MLR_ADDR_W-1:0] mem_addr, // operand address
  input wire logic [`MLR_DATA_W-1:0] mem_rdata, // byte at mem_addr
  input wire logic call_push, // call path pushes a return address
  input wire logic [`MLR_PC_W-1:0] call_addr, // address pushed
  output logic instr_ready, // slice takes an instruction
  output logic [`MLR_PC_W-1:0] pc, // program counter
  output logic [`MLR_DATA_W-1:0] acc, // accumulator
  output logic zero_flag, // zero flag
  output logic carry_flag, // carry flag
  output logic aux_carry_flag, // aux carry flag
  output logic overflow_flag, // overflow flag
  output logic global_interrupt_enable, // global interrupt enable
  output logic mem_we, // memory write strobe, one cycle
  output logic [`MLR_ADDR_W-1:0] mem_waddr, // memory write address
  output logic [`MLR_DATA_W-1:0] mem_wdata, // memory write data
  output logic skip // next instruction discarded, one cycle
);

  mlr_state_t st_q; // registered state
  mlr_state_t st_d; // next state
  logic accept; // instruction taken this edge
  logic is_pop; // any return form
  logic [`MLR_PC_W-1:0] stack_top; // return address
  logic [`MLR_DATA_W-1:0] alu_result; // datapath result
  logic alu_carry; // datapath carry
  logic alu_aux; // datapath aux carry
  logic alu_ovf; // datapath overflow
  logic alu_zero; // datapath zero

  assign accept = ce && instr_valid && st_q.ready;
  assign is_pop = accept && (instr_op == OP_SUBROUTINE_RETURN ||
    instr_op == OP_RETURN_VALUE || instr_op == OP_INTERRUPT_RETURN);

  // shared arithmetic and rotate datapath
  mlr_alu u_alu (
    .op(instr_op),
    .acc(st_q.acc),
    .mem(mem_rdata),
    .imm(instr_imm),
    .carry_in(st_q.carry_flag),
    .result(alu_result),
    .carry_out(alu_carry),
    .aux_carry_out(alu_aux),
    .overflow_out(alu_ovf),
    .zero_out(alu_zero)
  );

  // return addresses; popping happens on the accept edge
  mlr_ret_stack u_stack (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .push(call_push),
    .push_addr(call_addr),
    .pop(is_pop),
    .top(stack_top)
  );

  // next-state logic; flags hold unless an instruction names them
  always_comb begin
    st_d = st_q;
    st_d.mem_we = 1'b0;
    st_d.skip = 1'b0;
    unique case (st_q.fsm)
      ST_DUMMY: begin
        // second cycle of a return or a discarded fetch
        st_d.fsm = ST_RUN;
        st_d.ready = 1'b1;
      end
      ST_RUN: begin
        if (accept) begin
          st_d.pc = st_q.pc + `MLR_PC_STEP;
          st_d.mem_waddr = mem_addr;
          unique case (instr_op)
            OP_IDLE: begin
              st_d.pc = st_q.pc + `MLR_PC_STEP;
            end
            OP_COPY_MEM: st_d.acc = mem_rdata;
            OP_LOAD_IMM: st_d.acc = instr_imm;
            OP_STORE: begin
              st_d.mem_we = 1'b1;
              st_d.mem_wdata = st_q.acc;
            end
            OP_UNION_MEM, OP_UNION_IMM: begin
              st_d.acc = alu_result;
              st_d.zero_flag = alu_zero;
            end
            OP_UNION_TO_MEM: begin
              st_d.mem_we = 1'b1;
              st_d.mem_wdata = alu_result;
              st_d.zero_flag = alu_zero;
            end
            OP_SUBROUTINE_RETURN, OP_RETURN_VALUE,
            OP_INTERRUPT_RETURN: begin
              // the refetch after a pop costs one dummy cycle
              st_d.pc = stack_top;
              st_d.fsm = ST_DUMMY;
              st_d.ready = 1'b0;
              if (instr_op == OP_RETURN_VALUE) begin
                st_d.acc = instr_imm;
              end
              if (instr_op == OP_INTERRUPT_RETURN) begin
                st_d.global_interrupt_enable = 1'b1;
              end
            end
            OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
              st_d.mem_we = 1'b1;
              st_d.mem_wdata = alu_result;
            end
            OP_ROTATE_LEFT_TO_ACC, OP_ROTATE_RIGHT_TO_ACC: begin
              st_d.acc = alu_result;
            end
            OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY: begin
              st_d.mem_we = 1'b1;
              st_d.mem_wdata = alu_result;
              st_d.carry_flag = alu_carry;
            end
            OP_ROTATE_LEFT_CARRY_TO_ACC, OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
              st_d.acc = alu_result;
              st_d.carry_flag = alu_carry;
            end
            OP_SUBTRACT_BORROW, OP_SUBTRACT_BORROW_TO_MEM: begin
              if (instr_op == OP_SUBTRACT_BORROW_TO_MEM) begin
                st_d.mem_we = 1'b1;
                st_d.mem_wdata = alu_result;
              end else begin
                st_d.acc = alu_result;
              end
              st_d.carry_flag = alu_carry;
              st_d.aux_carry_flag = alu_aux;
              st_d.overflow_flag = alu_ovf;
              st_d.zero_flag = alu_zero;
            end
            OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_TO_ACC_SKIP_ZERO: begin
              if (instr_op == OP_DECREMENT_SKIP_ZERO) begin
                st_d.mem_we = 1'b1;
                st_d.mem_wdata = alu_result;
              end else begin
                st_d.acc = alu_result;
              end
              // zero result: the prefetched word is dropped
              if (alu_zero) begin
                st_d.pc = st_q.pc + `MLR_PC_SKIP;
                st_d.skip = 1'b1;
                st_d.fsm = ST_DUMMY;
                st_d.ready = 1'b0;
              end
            end
            default: st_d.pc = st_q.pc + `MLR_PC_STEP;
          endcase
        end
      end
      default: begin
        // unused gray codes recover to the run phase
        st_d.fsm = ST_RUN;
        st_d.ready = 1'b1;
      end
    endcase
  end

  // single state register; ce low freezes everything
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.fsm <= ST_RUN;
      st_q.ready <= 1'b1;
      st_q.pc <= `MLR_PC_RESET;
      st_q.acc <= `MLR_ACC_RESET;
      st_q.global_interrupt_enable <= `MLR_GIE_RESET;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // outputs are fields of the state register
  assign instr_ready = st_q.ready;
  assign pc = st_q.pc;
  assign acc = st_q.acc;
  assign zero_flag = st_q.zero_flag;
  assign carry_flag = st_q.carry_flag;
  assign aux_carry_flag = st_q.aux_carry_flag;
  assign overflow_flag = st_q.overflow_flag;
  assign global_interrupt_enable = st_q.global_interrupt_enable;
  assign mem_we = st_q.mem_we;
  assign mem_waddr = st_q.mem_waddr;
  assign mem_wdata = st_q.mem_wdata;
  assign skip = st_q.skip;

  // checks, sampled on the core clock
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic [3:0] flags_w; // packed flags for compact comparisons
  assign flags_w = {zero_flag, carry_flag, aux_carry_flag, overflow_flag};

  sequence s_take(mlr_op_t o);
    accept && instr_op == o;
  endsequence

  sequence s_dummy_then_run;
    !instr_ready ##1 (instr_ready || !ce);
  endsequence

  chk_copy_load: assert property (s_take(OP_COPY_MEM) |=>
    acc == $past(mem_rdata) && flags_w == $past(flags_w))
    else $error("copy did not load accumulator or moved a flag");

  chk_imm_load: assert property (s_take(OP_LOAD_IMM) |=>
    acc == $past(instr_imm) && $stable(flags_w))
    else $error("immediate load wrong");

  chk_store_write: assert property (s_take(OP_STORE) |=>
    mem_we && mem_wdata == $past(acc) && mem_waddr == $past(mem_addr))
    else $error("store did not write accumulator");

  chk_idle_pc: assert property (s_take(OP_IDLE) |=>
    pc == $past(pc) + 11'h001 && $stable(acc) && !mem_we && $stable(flags_w))
    else $error("idle changed state beyond pc");

  chk_union_zero: assert property (s_take(OP_UNION_IMM) |=>
    acc == ($past(acc) | $past(instr_imm)) && zero_flag == (acc == 8'h00))
    else $error("or immediate result or zero flag wrong");

  chk_ret_two: assert property (s_take(OP_SUBROUTINE_RETURN) |=>
    pc == $past(stack_top) && $stable(flags_w) ##0 s_dummy_then_run)
    else $error("return not two cycles or wrong pc");

  chk_retval_acc: assert property (s_take(OP_RETURN_VALUE) |=>
    acc == $past(instr_imm) && pc == $past(stack_top))
    else $error("return with value wrong");

  chk_interrupt_return_gie: assert property (s_take(OP_INTERRUPT_RETURN) |=>
    global_interrupt_enable && pc == $past(stack_top))
    else $error("interrupt return did not enable interrupts");

  chk_rotate_left: assert property (s_take(OP_ROTATE_LEFT_TO_ACC)
    |=> acc == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && !mem_we)
    else $error("rotate left to accumulator wrong");

  chk_rrc_carry: assert property (s_take(OP_ROTATE_RIGHT_CARRY) |=>
    carry_flag == $past(mem_rdata[0]) &&
    mem_wdata == {$past(carry_flag), $past(mem_rdata[7:1])})
    else $error("rotate right through carry wrong");

  chk_sub_borrow: assert property (s_take(OP_SUBTRACT_BORROW) |=>
    {carry_flag, acc} == {1'b0, $past(acc)} + {1'b0, ~$past(mem_rdata)} +
    {8'h00, $past(carry_flag)})
    else $error("subtract with carry result wrong");

  chk_dec_skip: assert property (s_take(OP_DECREMENT_SKIP_ZERO) ##0
    mem_rdata == 8'h01 |=> skip && pc == $past(pc) + 11'h002 &&
    mem_wdata == 8'h00 ##0 s_dummy_then_run)
    else $error("decrement skip did not skip");

  // carry rotate into the accumulator must leave memory alone
  chk_rlc_acc: assert property (s_take(OP_ROTATE_LEFT_CARRY_TO_ACC)
    |=> carry_flag == $past(mem_rdata[7]) && !mem_we &&
    acc == {$past(mem_rdata[6:0]), $past(carry_flag)})
    else $error("rotate left through carry to accumulator wrong");

  // memory form of or keeps the accumulator
  chk_union_mem: assert property (s_take(OP_UNION_TO_MEM) |=>
    mem_we && mem_wdata == ($past(acc) | $past(mem_rdata)) && $stable(acc))
    else $error("or to memory result wrong");

  // decrement into accumulator: no write, no flag, skip on zero
  chk_dec_acc: assert property (
    s_take(OP_DECREMENT_TO_ACC_SKIP_ZERO) |=> !mem_we && $stable(flags_w) &&
    acc == $past(mem_rdata) - 8'h01 && skip == (acc == 8'h00))
    else $error("decrement to accumulator wrong");

endmodule // mlr_exec
`default_nettype wire

// ==== mlr_consts.svh ====
// constants for the move, logic and rotate execution slice
// assumes a single core clock and a synchronous, active-high reset
// Behaviour
// - copy memory byte to accumulator, flags kept
// - load 8-bit immediate into accumulator, flags kept
// - store accumulator into memory, flags kept
// - idle only advances program counter by one
// - or with memory/immediate, only zero updated
// - return pops program counter, two cycles, flags kept
// - return with value loads accumulator, pops counter
// - interrupt return pops counter, sets interrupt enable
// - rotate left, bit 7 into bit 0
// - rotate left through carry, only carry changes
// - rotate right, bit 0 into bit 7
// - rotate right through carry, only carry changes
// - subtract with carry updates four arithmetic flags
// - decrement memory, skip when zero, two cycles
// - decrement into accumulator, skip when zero
`ifndef MLR_CONSTS_SVH
`define MLR_CONSTS_SVH

`define MLR_DATA_W 8
`define MLR_ADDR_W 7
`define MLR_PC_W 11
`define MLR_STACK_DEPTH 6
`define MLR_PTR_W 3
`define MLR_MSB 7
`define MLR_LSB 0
`define MLR_NIB_MSB 3
`define MLR_ACC_RESET 8'h00
`define MLR_PC_RESET 11'h000
`define MLR_FLAG_RESET 1'b0
`define MLR_GIE_RESET 1'b0
`define MLR_PC_STEP 11'h001
`define MLR_PC_SKIP 11'h002
`define MLR_RET_CYCLES 2
`define MLR_SKIP_CYCLES 2

`endif

// ==== mlr_pkg.sv ====
// types shared by the execution slice and its helpers
// assumes mlr_consts.svh is on the include path
`include "mlr_consts.svh"

package mlr_pkg;

  // instruction selector presented with each issued instruction
  typedef enum logic [4:0] {
    OP_IDLE = 5'h00,
    OP_COPY_MEM = 5'h01,
    OP_LOAD_IMM = 5'h02,
    OP_STORE = 5'h03,
    OP_UNION_MEM = 5'h04,
    OP_UNION_IMM = 5'h05,
    OP_UNION_TO_MEM = 5'h06,
    OP_SUBROUTINE_RETURN = 5'h07,
    OP_RETURN_VALUE = 5'h08,
    OP_INTERRUPT_RETURN = 5'h09,
    OP_ROTATE_LEFT = 5'h0A,
    OP_ROTATE_LEFT_TO_ACC = 5'h0B,
    OP_ROTATE_LEFT_CARRY = 5'h0C,
    OP_ROTATE_LEFT_CARRY_TO_ACC = 5'h0D,
    OP_ROTATE_RIGHT = 5'h0E,
    OP_ROTATE_RIGHT_TO_ACC = 5'h0F,
    OP_ROTATE_RIGHT_CARRY = 5'h10,
    OP_ROTATE_RIGHT_CARRY_TO_ACC = 5'h11,
    OP_SUBTRACT_BORROW = 5'h12,
    OP_SUBTRACT_BORROW_TO_MEM = 5'h13,
    OP_DECREMENT_SKIP_ZERO = 5'h14,
    OP_DECREMENT_TO_ACC_SKIP_ZERO = 5'h15
  } mlr_op_t;

  // gray-coded execution phase: run, then optional dummy cycle
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_DUMMY = 2'b01
  } mlr_fsm_t;

  // all state of the execution slice
  typedef struct packed {
    mlr_fsm_t fsm;
    logic ready;
    logic [`MLR_PC_W-1:0] pc;
    logic [`MLR_DATA_W-1:0] acc;
    logic zero_flag;
    logic carry_flag;
    logic aux_carry_flag;
    logic overflow_flag;
    logic global_interrupt_enable;
    logic mem_we;
    logic [`MLR_ADDR_W-1:0] mem_waddr;
    logic [`MLR_DATA_W-1:0] mem_wdata;
    logic skip;
  } mlr_state_t;

  // all state of the return stack
  typedef struct packed {
    logic [`MLR_STACK_DEPTH-1:0][`MLR_PC_W-1:0] slot;
    logic [`MLR_PTR_W-1:0] ptr;
  } mlr_stack_t;

endpackage

// ==== mlr_alu.sv ====
// combinational datapath for or, rotates, subtract-with-carry, decrement
// assumes the caller registers every result and chooses which flags to keep
`timescale 1ns/1ps
`default_nettype none
`include "mlr_consts.svh"

module mlr_alu
  import mlr_pkg::*;
(
  input wire mlr_op_t op, // instruction selector
  input wire logic [`MLR_DATA_W-1:0] acc, // accumulator value
  input wire logic [`MLR_DATA_W-1:0] mem, // addressed memory byte
  input wire logic [`MLR_DATA_W-1:0] imm, // immediate field
  input wire logic carry_in, // current carry flag
  output logic [`MLR_DATA_W-1:0] result, // computed byte
  output logic carry_out, // new carry
  output logic aux_carry_out, // carry out of low nibble
  output logic overflow_out, // signed overflow
  output logic zero_out // result is zero
);

  logic [`MLR_DATA_W:0] diff; // full subtract sum with carry out
  logic [`MLR_NIB_MSB+1:0] low_nib; // low nibble sum for aux carry
  logic [`MLR_DATA_W-1:0] mem_inv; // inverted operand

  // one shared adder for subtract-with-carry: acc + ~m + c
  always_comb begin
    mem_inv = ~mem;
    diff = {1'b0, acc} + {1'b0, mem_inv} + {8'h00, carry_in};
    low_nib = {1'b0, acc[`MLR_NIB_MSB:0]} + {1'b0, mem_inv[`MLR_NIB_MSB:0]}
      + {4'h0, carry_in};
  end

  // result select; carry defaults to the old value
  always_comb begin
    result = acc;
    carry_out = carry_in;
    aux_carry_out = low_nib[`MLR_NIB_MSB+1];
    overflow_out = (acc[`MLR_MSB] == mem_inv[`MLR_MSB]) &&
      (diff[`MLR_MSB] != acc[`MLR_MSB]);
    unique case (op)
      OP_UNION_MEM, OP_UNION_TO_MEM: result = acc | mem;
      OP_UNION_IMM: result = acc | imm;
      OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_ACC: begin
        result = {mem[`MLR_MSB-1:0], mem[`MLR_MSB]};
      end
      OP_ROTATE_LEFT_CARRY, OP_ROTATE_LEFT_CARRY_TO_ACC: begin
        result = {mem[`MLR_MSB-1:0], carry_in};
        carry_out = mem[`MLR_MSB];
      end
      OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_TO_ACC: begin
        result = {mem[`MLR_LSB], mem[`MLR_MSB:1]};
      end
      OP_ROTATE_RIGHT_CARRY, OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
        result = {carry_in, mem[`MLR_MSB:1]};
        carry_out = mem[`MLR_LSB];
      end
      OP_SUBTRACT_BORROW, OP_SUBTRACT_BORROW_TO_MEM: begin
        result = diff[`MLR_DATA_W-1:0];
        carry_out = diff[`MLR_DATA_W];
      end
      OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_TO_ACC_SKIP_ZERO: begin
        result = mem - 8'h01;
      end
      default: result = acc; // other ops do not use the adder result
    endcase
    zero_out = (result == 8'h00);
  end

endmodule // mlr_alu
`default_nettype wire

// ==== mlr_ret_stack.sv ====
// six-level return stack: push from the call path, pop on return
// assumes push and pop never arrive together; pop wins if they do
`timescale 1ns/1ps
`default_nettype none
`include "mlr_consts.svh"

module mlr_ret_stack
  import mlr_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes state when low
  input wire logic push, // push request
  input wire logic [`MLR_PC_W-1:0] push_addr, // return address to store
  input wire logic pop, // pop request
  output logic [`MLR_PC_W-1:0] top // current top entry
);

  mlr_stack_t s_q; // registered stack
  mlr_stack_t s_d; // next stack
  logic [`MLR_PTR_W-1:0] top_idx; // index of top entry

  // circular indexing: a seventh push silently overwrites the oldest
  always_comb begin
    s_d = s_q;
    top_idx = (s_q.ptr == 3'h0) ? 3'(`MLR_STACK_DEPTH - 1) : s_q.ptr - 3'h1;
    if (pop) begin
      s_d.ptr = top_idx;
    end else if (push) begin
      s_d.slot[s_q.ptr] = push_addr;
      s_d.ptr = (s_q.ptr == 3'(`MLR_STACK_DEPTH - 1)) ? 3'h0 : s_q.ptr + 3'h1;
    end
  end

  assign top = s_q.slot[top_idx];

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

endmodule // mlr_ret_stack
`default_nettype wire

// ==== mlr_mem_model.sv ====
// data memory model standing beside the execution slice
// assumes reads are combinational and writes come as a registered strobe
`timescale 1ns/1ps
`default_nettype none
`include "mlr_consts.svh"

module mlr_mem_model (
  input wire logic core_clk, // core clock
  input wire logic [`MLR_ADDR_W-1:0] mem_addr, // read address
  output logic [`MLR_DATA_W-1:0] mem_rdata, // byte at read address
  input wire logic mem_we, // write strobe
  input wire logic [`MLR_ADDR_W-1:0] mem_waddr, // write address
  input wire logic [`MLR_DATA_W-1:0] mem_wdata // write byte
);
  logic [`MLR_DATA_W-1:0] ram [0:127]; // bench preloads operands here
  // operand must arrive in the cycle the instruction is offered
  assign mem_rdata = ram[mem_addr];
  // write lands on the edge that sees the strobe
  always @(posedge core_clk) begin
    if (mem_we === 1'b1) begin
      ram[mem_waddr] <= mem_wdata;
    end
  end
endmodule // mlr_mem_model
`default_nettype wire

// ==== mcu_move_logic_rotate_exec_tb.sv ====
// self-checking bench for the execution slice and its data memory model
// assumes results show one cycle after the slice takes an instruction
`timescale 1ns/1ps
`default_nettype none
`include "mlr_consts.svh"

module mcu_move_logic_rotate_exec_tb
  import mlr_pkg::*;
;
  logic core_clk = 1'b0; // core clock
  logic rst = 1'b1; // reset, held at start
  logic ce = 1'b1; // left running: freeze is not part of these scenarios
  logic instr_valid = 1'b0; // instruction offered
  mlr_op_t instr_op = OP_IDLE; // selector
  logic [7:0] instr_imm = 8'h00; // immediate
  logic [6:0] mem_addr = 7'h00; // operand address
  logic [7:0] mem_rdata; // operand byte
  logic call_push = 1'b0; // stack push pulse
  logic [10:0] call_addr = 11'h000; // pushed address
  logic instr_ready, mem_we, skip; // slice handshake and strobes
  logic [10:0] pc; // program counter
  logic [7:0] acc, mem_wdata; // accumulator and write byte
  logic [6:0] mem_waddr; // write address
  logic zero_flag, carry_flag, aux_carry_flag, overflow_flag; // flags
  logic global_interrupt_enable; // interrupt enable
  logic [10:0] e_pc = 11'h000; // expected counter
  logic [7:0] e_acc = 8'h00; // expected accumulator
  logic e_z = 1'b0, e_c = 1'b0, e_a = 1'b0, e_v = 1'b0, e_g = 1'b0; // flags
  logic [10:0] stk [$]; // expected return stack
  int n_errors = 0; // mismatches
  int n_compared = 0; // comparisons

  mlr_exec uut (.core_clk, .rst, .ce, .instr_valid, .instr_op, .instr_imm,
    .mem_addr, .mem_rdata, .call_push, .call_addr, .instr_ready, .pc, .acc,
    .zero_flag, .carry_flag, .aux_carry_flag, .overflow_flag,
    .global_interrupt_enable, .mem_we, .mem_waddr, .mem_wdata, .skip);
  mlr_mem_model u_mem (.core_clk, .mem_addr, .mem_rdata, .mem_we,
    .mem_waddr, .mem_wdata);

  // free-running 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  // one comparison, counted; unknowns never match
  task automatic chk(input string what, input logic [10:0] exp,
                     input logic [10:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // pc, accumulator, four flags and interrupt enable against the bench's own model
  task automatic check_state();
    chk("pc", e_pc, pc);
    chk("acc", {3'h0, e_acc}, {3'h0, acc});
    chk("z", {10'h000, e_z}, {10'h000, zero_flag});
    chk("c", {10'h000, e_c}, {10'h000, carry_flag});
    chk("aux", {10'h000, e_a}, {10'h000, aux_carry_flag});
    chk("ovf", {10'h000, e_v}, {10'h000, overflow_flag});
    chk("gie", {10'h000, e_g}, {10'h000, global_interrupt_enable});
  endtask

  // issue one instruction with operand m, predict and judge the outcome
  task automatic run_op(input mlr_op_t op, input logic [7:0] imm,
                        input logic [6:0] a, input logic [7:0] m);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic wr, sk, two;
    u_mem.ram[a] = m;
    r = e_acc;
    wr = 1'b0;
    sk = 1'b0;
    two = 1'b0;
    s = {1'b0, e_acc} + {1'b0, ~m} + {8'h00, e_c};
    h = {1'b0, e_acc[3:0]} + {1'b0, ~m[3:0]} + {4'h0, e_c};
    e_pc = e_pc + 11'h001;
    case (op)
      OP_COPY_MEM: e_acc = m;
      OP_LOAD_IMM: e_acc = imm;
      OP_STORE: wr = 1'b1;
      OP_UNION_MEM, OP_UNION_IMM, OP_UNION_TO_MEM: begin
        r = e_acc | ((op == OP_UNION_IMM) ? imm : m);
        e_z = (r == 8'h00);
        if (op == OP_UNION_TO_MEM) wr = 1'b1;
        else e_acc = r;
      end
      OP_SUBROUTINE_RETURN, OP_RETURN_VALUE, OP_INTERRUPT_RETURN: begin
        e_pc = stk.pop_back();
        two = 1'b1;
        if (op == OP_RETURN_VALUE) e_acc = imm;
        if (op == OP_INTERRUPT_RETURN) e_g = 1'b1;
      end
      OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_ACC: r = {m[6:0], m[7]};
      OP_ROTATE_LEFT_CARRY, OP_ROTATE_LEFT_CARRY_TO_ACC: begin
        r = {m[6:0], e_c};
        e_c = m[7];
      end
      OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_TO_ACC: r = {m[0], m[7:1]};
      OP_ROTATE_RIGHT_CARRY, OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
        r = {e_c, m[7:1]};
        e_c = m[0];
      end
      OP_SUBTRACT_BORROW, OP_SUBTRACT_BORROW_TO_MEM: begin
        r = s[7:0];
        e_v = (e_acc[7] == ~m[7]) && (r[7] != e_acc[7]);
        e_a = h[4];
        e_c = s[8];
        e_z = (r == 8'h00);
      end
      OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_TO_ACC_SKIP_ZERO: begin
        r = m - 8'h01;
        sk = (r == 8'h00);
      end
      default: ;
    endcase
    // memory forms write the byte, the rest land in the accumulator
    if (op >= OP_ROTATE_LEFT) begin
      if (op inside {OP_ROTATE_LEFT, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT,
          OP_ROTATE_RIGHT_CARRY, OP_SUBTRACT_BORROW_TO_MEM,
          OP_DECREMENT_SKIP_ZERO}) wr = 1'b1;
      else e_acc = r;
    end
    if (sk) begin
      e_pc = e_pc + 11'h001;
      two = 1'b1;
    end
    instr_valid = 1'b1;
    instr_op = op;
    instr_imm = imm;
    mem_addr = a;
    @(posedge core_clk);
    #1;
    instr_valid = 1'b0;
    check_state();
    chk("mem_we", {10'h000, wr}, {10'h000, mem_we});
    if (wr) begin
      chk("wdata", {3'h0, r}, {3'h0, mem_wdata});
      chk("waddr", {4'h0, a}, {4'h0, mem_waddr});
    end
    chk("skip", {10'h000, sk}, {10'h000, skip});
    chk("ready", {10'h000, ~two}, {10'h000, instr_ready});
    @(posedge core_clk);
    #1;
    chk("ram", {3'h0, wr ? r : m}, {3'h0, u_mem.ram[a]});
    chk("we pulse", 11'h000, {10'h000, mem_we});
    chk("skip pulse", 11'h000, {10'h000, skip});
    chk("ready back", 11'h001, {10'h000, instr_ready});
  endtask

  // one-cycle push onto the return stack
  task automatic push(input logic [10:0] ra);
    call_push = 1'b1;
    call_addr = ra;
    @(posedge core_clk);
    #1;
    call_push = 1'b0;
    stk.push_back(ra);
  endtask

  // state straight out of reset
  task automatic t_reset();
    check_state();
    chk("ready rst", 11'h001, {10'h000, instr_ready});
  endtask

  // moves and idle keep every flag
  task automatic t_moves();
    run_op(OP_LOAD_IMM, 8'hA5, 7'h00, 8'h00);
    run_op(OP_STORE, 8'h00, 7'h10, 8'h5A);
    run_op(OP_COPY_MEM, 8'h00, 7'h20, 8'h3C);
    run_op(OP_IDLE, 8'hFF, 7'h21, 8'h77);
  endtask

  // union sets zero only from an all-zero result
  task automatic t_union();
    run_op(OP_LOAD_IMM, 8'h00, 7'h00, 8'h00);
    run_op(OP_UNION_IMM, 8'h00, 7'h00, 8'hFF);
    run_op(OP_UNION_MEM, 8'h00, 7'h31, 8'h81);
    run_op(OP_UNION_TO_MEM, 8'h00, 7'h32, 8'h02);
  endtask

  // every rotate form, twice; carry enters both ways in the rotate-left and rotate-right through-carry forms
  task automatic t_rotates();
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 8; i++) begin
        run_op(mlr_op_t'(5'h0A + 5'(i)), 8'h00, 7'(7'h40 + i),
               8'(8'h81 + 37 * (i + j)));
      end
    end
  endtask

  // subtract with carry across sign, zero and borrow corners
  task automatic t_subtract();
    logic [7:0] av [6] = '{8'h05, 8'h80, 8'h00, 8'h7F, 8'h10, 8'hFF};
    logic [7:0] mv [6] = '{8'h03, 8'h01, 8'h00, 8'hFF, 8'h10, 8'hFE};
    for (int i = 0; i < 6; i++) begin
      run_op(OP_LOAD_IMM, av[i], 7'h00, 8'h00);
      run_op(i[0] ? OP_SUBTRACT_BORROW_TO_MEM : OP_SUBTRACT_BORROW, 8'h00,
             7'h50, mv[i]);
    end
  endtask

  // decrement with and without the skip, both destinations
  task automatic t_decrement();
    run_op(OP_DECREMENT_SKIP_ZERO, 8'h00, 7'h60, 8'h01);
    run_op(OP_DECREMENT_SKIP_ZERO, 8'h00, 7'h61, 8'h05);
    run_op(OP_DECREMENT_TO_ACC_SKIP_ZERO, 8'h00, 7'h62, 8'h01);
    run_op(OP_DECREMENT_TO_ACC_SKIP_ZERO, 8'h00, 7'h63, 8'h00);
  endtask

  // the three return forms pop in reverse push order
  task automatic t_returns();
    push(11'h123);
    push(11'h2AB);
    push(11'h055);
    run_op(OP_SUBROUTINE_RETURN, 8'h00, 7'h00, 8'h00);
    run_op(OP_RETURN_VALUE, 8'h5A, 7'h00, 8'h00);
    run_op(OP_INTERRUPT_RETURN, 8'h00, 7'h00, 8'h00);
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // main sequence after an 8-cycle reset
  initial begin
    repeat (8) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_moves();
    t_union();
    t_rotates();
    t_subtract();
    t_decrement();
    t_returns();
    report_and_stop();
  end

  // watchdog: the scenarios need far fewer than 2000 cycles
  initial begin
    #(5 * 2000);
    n_errors++;
    report_and_stop();
  end
endmodule // mcu_move_logic_rotate_exec_tb
`default_nettype wire
